// ==== bench/pbarb_monitor.sv ====
`timescale 1ns/1ps
// ---
// arbitration checker
// ---
module pbarb_monitor (
	input wire clk_i,
	input wire reset_i,
	input wire cfn_n_i,
	input wire up_need_i,
	input wire up_withdraw_i,
	input wire up_req_n_o,
	input wire up_start_o,
	input wire up_park_o,
	input wire [5:0] dn_gnt_n_o,
	input wire dn_frame_n_i,
	input wire dn_irdy_n_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	reg [4:0] idle_ff;
	// age of an unused grant; saturates so a kept grant keeps firing every clock instead of wrapping back under the limit
	always @(posedge clk_i) begin
		if (reset_i || cfn_n_i || dn_gnt_n_o == 6'h3F || !dn_frame_n_i || !dn_irdy_n_i)
			idle_ff <= 5'h00;
		else if (idle_ff != 5'h1F)
			idle_ff <= idle_ff + 5'h01;
	end
	a_req_on_need: assert property ($rose(up_need_i) && !up_withdraw_i |=> !up_req_n_o)
		else $error("request missing");
	a_start_drops_req: assert property (up_start_o |-> up_req_n_o && !$past(up_req_n_o))
		else $error("start without request");
	a_start_pulse: assert property (up_start_o |=> !up_start_o)
		else $error("start too long");
	a_withdraw_req: assert property (up_withdraw_i |=> up_req_n_o)
		else $error("withdraw ignored");
	a_park_no_req: assert property (up_park_o |-> up_req_n_o)
		else $error("parked while requesting");
	a_one_grant: assert property ($onehot0(~dn_gnt_n_o))
		else $error("two grants");
	a_ext_upper: assert property (cfn_n_i [*8] |-> dn_gnt_n_o[5:1] == 5'h1F)
		else $error("upper grant in external mode");
	a_idle_grant: assert property (idle_ff <= 5'd18)
		else $error("unused grant kept");
	cover property (up_start_o);
	cover property (idle_ff == 5'd16);
	cover property (cfn_n_i [*8] ##1 !dn_gnt_n_o[0]);
endmodule // pbarb_monitor

bind pci_bridge_bus_arbitration pbarb_monitor pbarb_monitor_inst (.clk_i, .reset_i,
	.cfn_n_i, .up_need_i, .up_withdraw_i, .up_req_n_o, .up_start_o, .up_park_o,
	.dn_gnt_n_o, .dn_frame_n_i, .dn_irdy_n_i);

// ==== bench/pci_masters_model.sv ====
`timescale 1ns/1ps
// ---
// upstream arbiter and downstream masters
// ---
module pci_masters_model (
	input wire clk_i,
	input wire ext_i,
	input wire [5:0] want_i,
	input wire [5:0] lazy_i,
	input wire up_req_n_i,
	input wire [5:0] gnt_n_i,
	output reg up_gnt_n_o = 1'b1,
	output reg [5:0] req_n_o,
	output reg frame_n_o
);
	reg [1:0] busy_ff = 2'h0;
	reg [5:0] done_ff = 6'h00;
	reg ext_gnt_ff = 1'b1;
	integer i;
	// pins sampled on rising edge; lazy masters never start a frame
	always @(posedge clk_i) begin
		up_gnt_n_o <= up_req_n_i;
		ext_gnt_ff <= gnt_n_i[0];
		done_ff <= done_ff & want_i;
		if (busy_ff != 2'h0)
			busy_ff <= busy_ff - 2'h1;
		else if (!ext_i)
			for (i = 0; i < 6; i = i + 1)
				if (!gnt_n_i[i] && want_i[i] && !lazy_i[i] && !done_ff[i]) begin
					busy_ff <= 2'h3;
					done_ff[i] <= 1'b1;
				end
	end
	// served masters drop request; pin 0 is the grant in external mode
	always @* begin
		frame_n_o = busy_ff == 2'h0;
		req_n_o = ~(want_i & ~done_ff);
		if (ext_i)
			req_n_o[0] = ext_gnt_ff;
	end
endmodule // pci_masters_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
// ---
// arbitration bench
// ---
module tb;
	reg clk_i = 0, reset_i = 1, cfn_n_i = 0, arb_mode_i = 0, up_need_i = 0;
	reg up_withdraw_i = 0, dn_need_i = 0, posted_i = 0, retry_i = 0;
	reg [7:0] mask_clocks_i = 8'h04;
	reg [2:0] retry_idx_i = 3'h0;
	reg [5:0] want = 6'h00, lazy = 6'h00;
	wire up_gnt_n, up_req_n_o, up_start_o, up_park_o, dn_start_o, data_ok_o, dn_park_o;
	wire frame_n;
	wire [5:0] dn_req_n, dn_gnt_n_o;
	integer seed = 7929, error_cnt = 0, compares = 0, cyc = 0, n, t;
	initial forever #50 clk_i = ~clk_i;
	pci_bridge_bus_arbitration pci_bridge_bus_arbitration_inst (.clk_i, .reset_i, .cfn_n_i,
		.arb_mode_i, .mask_clocks_i, .up_gnt_n_i(up_gnt_n), .up_frame_n_i(1'b1),
		.up_irdy_n_i(1'b1), .up_req_n_o, .up_start_o, .up_park_o, .up_need_i, .up_withdraw_i,
		.dn_need_i, .posted_i, .dn_start_o, .data_ok_o, .dn_req_n_i(dn_req_n), .dn_gnt_n_o,
		.dn_frame_n_i(frame_n), .dn_irdy_n_i(frame_n), .dn_park_o, .retry_i, .retry_idx_i);
	pci_masters_model pci_masters_model_inst (.clk_i, .ext_i(cfn_n_i), .want_i(want),
		.lazy_i(lazy), .up_req_n_i(up_req_n_o), .gnt_n_i(dn_gnt_n_o), .up_gnt_n_o(up_gnt_n),
		.req_n_o(dn_req_n), .frame_n_o(frame_n));
	// one compare, counted; x never passes
	task chk(input ok);
		begin
			compares = compares + 1;
			if (ok !== 1'b1) begin
				error_cnt = error_cnt + 1;
				$display("BAD %0t arbiter output wrong", $time);
			end
		end
	endtask
	task complete_run;
		begin
			$display("compares %0d error_cnt %0d", compares, error_cnt);
			if (error_cnt == 0 && compares > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			complete_run;
		end
	end
	// expected grant age window for an unused grant
	function exp_age(input integer age);
		exp_age = age >= 16 && age <= 18;
	endfunction
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 0;
		repeat (6) @(posedge clk_i);
		up_need_i <= 1;
		@(negedge clk_i);
		@(negedge clk_i);
		chk(up_req_n_o === 1'b0);
		chk(dn_park_o === 1'b1);
		n = 0;
		while (up_start_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n = n + 1;
		end
		chk(up_start_o === 1'b1 && up_req_n_o === 1'b1);
		@(posedge clk_i) up_need_i <= 0;
		repeat (8) @(posedge clk_i);
		up_need_i <= 1;
		@(posedge clk_i) up_withdraw_i <= 1;
		@(negedge clk_i);
		@(negedge clk_i);
		chk(up_req_n_o === 1'b1);
		@(posedge clk_i) up_withdraw_i <= 0;
		up_need_i <= 0;
		$display("upstream done");
		// random requests in both modes, with retries; all must be served
		for (t = 0; t < 40; t = t + 1) begin
			@(posedge clk_i) want <= 6'h00;
			@(posedge clk_i) arb_mode_i <= t[0];
			want <= $random(seed);
			dn_need_i <= $random(seed);
			posted_i <= $random(seed);
			mask_clocks_i <= 8'h0F & $random(seed);
			retry_idx_i <= $unsigned($random(seed)) % 6;
			retry_i <= 1;
			@(posedge clk_i) retry_i <= 0;
			dn_need_i <= 0;
			n = 0;
			while (dn_req_n !== 6'h3F && n < 300) begin
				@(negedge clk_i);
				n = n + 1;
			end
			chk(dn_req_n === 6'h3F);
		end
		$display("random done");
		@(posedge clk_i) want <= 6'h00;
		@(posedge clk_i) lazy <= 6'h08;
		want <= 6'h08;
		n = 0;
		while (dn_gnt_n_o[3] !== 1'b0 && n < 30) begin
			@(negedge clk_i);
			n = n + 1;
		end
		n = 0;
		while (dn_gnt_n_o[3] === 1'b0 && n < 40) begin
			@(negedge clk_i);
			n = n + 1;
		end
		chk(exp_age(n));
		repeat (30) @(negedge clk_i) if (dn_gnt_n_o[3] === 1'b0) n = 99;
		chk(n < 99);
		@(posedge clk_i) want <= 6'h00;
		lazy <= 6'h00;
		$display("timeout done");
		@(posedge clk_i) cfn_n_i <= 1;
		repeat (10) @(posedge clk_i);
		want <= 6'h3F;
		repeat (10) @(negedge clk_i);
		chk(dn_gnt_n_o[5:1] === 5'h1F);
		@(posedge clk_i) dn_need_i <= 1;
		posted_i <= 1;
		n = 0;
		while (dn_gnt_n_o[0] !== 1'b0 && n < 20) begin
			@(negedge clk_i);
			n = n + 1;
		end
		chk(dn_gnt_n_o[0] === 1'b0);
		n = 0;
		while (data_ok_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n = n + 1;
		end
		chk(data_ok_o === 1'b1 && dn_start_o === 1'b1);
		@(posedge clk_i) dn_need_i <= 0;
		$display("external done");
		repeat (10) @(posedge clk_i);
		complete_run;
	end
endmodule // tb

// ==== rtl/mask_timer.v ====
`timescale 1ns/1ps
// ----------------------------------------
// shared retry mask timer
// ----------------------------------------
`include "pbarb_defs.vh"
module mask_timer (
	input wire clk_i,
	input wire reset_i,
	input wire [7:0] mask_clocks_i,
	input wire retry_i,
	input wire [2:0] retry_idx_i,
	output reg [5:0] mask_o
);
	reg [7:0] count_ff;

	// one timer for all masters; a later retry joins the running interval
	always @(posedge clk_i) begin
		if (reset_i) begin
			count_ff <= 8'h00;
			mask_o <= 6'h00;
		end else begin
			if (retry_i && retry_idx_i < 3'h6) begin
				if (count_ff == 8'h00) begin
					count_ff <= mask_clocks_i;
				end else begin
					count_ff <= count_ff - 8'h01;
				end
				if (mask_clocks_i != 8'h00 || count_ff > 8'h01) begin
					mask_o <= mask_o | (6'h01 << retry_idx_i);
				end
			end else if (count_ff > 8'h01) begin
				count_ff <= count_ff - 8'h01;
			end else begin
				count_ff <= 8'h00;
				mask_o <= 6'h00; // expired, serve again
			end
		end
	end
endmodule // mask_timer

// ==== rtl/pbarb_defs.vh ====
`ifndef PBARB_DEFS_VH
`define PBARB_DEFS_VH

// ----------------------------------------
// request numbering on the downstream bus
// ----------------------------------------
`define NUM_EXT 6
`define NUM_REQ 7
`define BRIDGE_IDX 6

// ----------------------------------------
// timing
// ----------------------------------------
`define IDLE_GNT_LIMIT 16
`define MASK_TMR_W 8
`define IDLE_CNT_W 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_GNT_N 6'h3F
`define RST_PTR 3'h0

`endif

// ==== rtl/pci_bridge_bus_arbitration.v ====
`timescale 1ns/1ps
// How it works
// - upstream request asserts while a downstream transaction waits to go upstream
// - clock after grant on idle bus: start frame, address, command, drop request
// - upstream request may be withdrawn before the transaction begins
// - upstream idle-bus drive only with grant asserted and request deasserted
// - strap low: internal downstream arbiter; strap high: outside arbiter
// - internal arbiter serves six external masters plus the bridge
// - bridge requests downstream only for upstream initiators; grants independent of upstream
// - non-posted crossings need both buses before data moves
// - every downstream frame start re-assigns priority; grant highest asserted request
// - higher-priority request displaces current grant on the next clock
// - busy bus may switch in one clock; idle bus needs two empty clocks
// - grant unused 16 idle clocks is removed; master locked out until request drops
// - mode low: bridge top on alternate cycles, externals rotate otherwise
// - mode high: top priority rotates across all seven requesters
// - target retry starts mask timer; master ignored for programmed clocks
// - retry during running timer masks only for the remaining clocks
// - strap high: grant pin 0 is request out, request pin 0 grant in
// - external downstream exchange follows the upstream request/grant protocol
// - internal mode parks bridge on idle bus; external only with grant input
`include "pbarb_defs.vh"
module pci_bridge_bus_arbitration (
	input wire clk_i,
	input wire reset_i,
	// strap and control
	input wire cfn_n_i,
	input wire arb_mode_i,
	input wire [7:0] mask_clocks_i,
	// upstream bus
	input wire up_gnt_n_i,
	input wire up_frame_n_i,
	input wire up_irdy_n_i,
	output reg up_req_n_o,
	output reg up_start_o,
	output reg up_park_o,
	// bridge core: upstream forwarding
	input wire up_need_i,
	input wire up_withdraw_i,
	// bridge core: downstream forwarding
	input wire dn_need_i,
	input wire posted_i,
	output reg dn_start_o,
	output reg data_ok_o,
	// downstream bus
	input wire [5:0] dn_req_n_i,
	output reg [5:0] dn_gnt_n_o,
	input wire dn_frame_n_i,
	input wire dn_irdy_n_i,
	output reg dn_park_o,
	input wire retry_i,
	input wire [2:0] retry_idx_i
);
	// ----------------------------------------
	// pin input synchronisers
	// ----------------------------------------
	reg [2:0] cfn_s_ff;
	reg cfn_ff;
	reg [5:0] req_s1_ff, req_s2_ff, req_s3_ff;
	reg [5:0] req_ff;
	reg [2:0] ug_s_ff;
	reg up_gnt_ff;
	reg [2:0] uf_s_ff, ui_s_ff, df_s_ff, di_s_ff;
	reg up_frame_ff, up_irdy_ff, dn_frame_ff, dn_irdy_ff;

	// strap: a resistor-tied pin, so it may still bounce just after power-up
	always @(posedge clk_i) begin
		if (reset_i) begin
			cfn_s_ff <= 3'h0;
			cfn_ff <= 1'b0;
		end else begin
			cfn_s_ff <= {cfn_s_ff[1:0], cfn_n_i};
			if (cfn_s_ff[1] == cfn_s_ff[2])
				cfn_ff <= cfn_s_ff[2];
		end
	end

	// bus pins are outside this clock: accept a change only once two stages agree
	always @(posedge clk_i) begin
		if (reset_i) begin
			req_s1_ff <= 6'h3F;
			req_s2_ff <= 6'h3F;
			req_s3_ff <= 6'h3F;
			req_ff <= 6'h00;
			ug_s_ff <= 3'h7;
			up_gnt_ff <= 1'b0;
			uf_s_ff <= 3'h7;
			ui_s_ff <= 3'h7;
			df_s_ff <= 3'h7;
			di_s_ff <= 3'h7;
			up_frame_ff <= 1'b0;
			up_irdy_ff <= 1'b0;
			dn_frame_ff <= 1'b0;
			dn_irdy_ff <= 1'b0;
		end else begin
			req_s1_ff <= dn_req_n_i;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
			ug_s_ff <= {ug_s_ff[1:0], up_gnt_n_i};
			uf_s_ff <= {uf_s_ff[1:0], up_frame_n_i};
			ui_s_ff <= {ui_s_ff[1:0], up_irdy_n_i};
			df_s_ff <= {df_s_ff[1:0], dn_frame_n_i};
			di_s_ff <= {di_s_ff[1:0], dn_irdy_n_i};
			// active low pins turned to active high levels
			req_ff <= ~req_s3_ff & ~(req_s2_ff ^ req_s3_ff) | req_ff & (req_s2_ff ^ req_s3_ff);
			if (ug_s_ff[1] == ug_s_ff[2])
				up_gnt_ff <= ~ug_s_ff[2];
			if (uf_s_ff[1] == uf_s_ff[2])
				up_frame_ff <= ~uf_s_ff[2];
			if (ui_s_ff[1] == ui_s_ff[2])
				up_irdy_ff <= ~ui_s_ff[2];
			if (df_s_ff[1] == df_s_ff[2])
				dn_frame_ff <= ~df_s_ff[2];
			if (di_s_ff[1] == di_s_ff[2])
				dn_irdy_ff <= ~di_s_ff[2];
		end
	end

	// ----------------------------------------
	// request/grant master end, shared shape
	// ----------------------------------------
	// returns {req, start, park} for a master with need, withdraw, grant, idle
	function [2:0] master_step;
		input need;
		input withdraw;
		input gnt;
		input idle;
		input req_now;
		begin
			if (req_now && gnt && idle)
				master_step = 3'b010; // start, drop request
			else if (need && !withdraw)
				master_step = 3'b100;
			else
				master_step = {1'b0, 1'b0, gnt && idle};
		end
	endfunction

	// wrap-around increment for the rotating pointers
	function [2:0] ptr_next;
		input [2:0] ptr;
		input [2:0] last;
		begin
			if (ptr == last)
				ptr_next = 3'h0;
			else
				ptr_next = ptr + 3'h1;
		end
	endfunction

	// watchdog limit reached on an idle bus; the grant goes away this clock
	function stale_hit;
		input [4:0] cnt;
		input idle;
		begin
			stale_hit = idle && (cnt >= `IDLE_GNT_LIMIT - 1);
		end
	endfunction

	wire up_idle = !up_frame_ff && !up_irdy_ff;
	wire dn_idle = !dn_frame_ff && !dn_irdy_ff;
	wire [2:0] up_step = master_step(up_need_i, up_withdraw_i, up_gnt_ff, up_idle, ~up_req_n_o);
	reg up_owned_ff;

	// ----------------------------------------
	// upstream master end
	// ----------------------------------------
	// start needs a standing request, so a stale grant alone never opens a frame
	always @(posedge clk_i) begin
		if (reset_i) begin
			up_req_n_o <= 1'b1;
			up_start_o <= 1'b0;
			up_park_o <= 1'b0;
			up_owned_ff <= 1'b0;
		end else begin
			up_req_n_o <= ~up_step[2];
			up_start_o <= up_step[1];
			up_park_o <= up_step[0] && up_req_n_o;
			if (up_step[1])
				up_owned_ff <= 1'b1;
			else if (!up_need_i)
				up_owned_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// internal downstream arbiter
	// ----------------------------------------
	reg [2:0] ext_ptr_ff;
	reg [2:0] all_ptr_ff;
	reg bridge_turn_ff;
	reg [6:0] gnt_ff;
	reg [5:0] lock_ff;
	reg [4:0] idle_cnt_ff;
	reg dn_frame_d_ff;
	reg gap_ff;
	wire [5:0] mask;
	wire found;
	wire [2:0] win;
	reg [2:0] top;
	reg [6:0] req_eff;
	reg [6:0] nxt_gnt;
	reg dn_req_ext_ff;
	reg dn_start_ff;

	// one shared timer; masters retried late inherit its remaining count
	mask_timer u_mask (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.mask_clocks_i(mask_clocks_i),
		.retry_i(retry_i),
		.retry_idx_i(retry_idx_i),
		.mask_o(mask)
	);

	// ----------------------------------------
	// effective requests and grant choice
	// ----------------------------------------
	// bridge enters a request only on behalf of an upstream initiator
	always @* begin
		req_eff = {dn_need_i, req_ff & ~mask & ~lock_ff};
		if (arb_mode_i)
			top = all_ptr_ff;
		else if (bridge_turn_ff)
			top = 3'h6;
		else
			top = ext_ptr_ff;
	end

	// pure combinational scan, so a new winner shows up in the same clock
	prio_pick u_pick (
		.req_i(req_eff),
		.top_i(top),
		.found_o(found),
		.idx_o(win)
	);

	// grant choice: busy bus switches at once, idle bus leaves two empty clocks
	always @* begin
		nxt_gnt = 7'h00;
		if (found)
			nxt_gnt = 7'h01 << win;
		if (gnt_ff != 7'h00 && nxt_gnt != gnt_ff && dn_idle)
			nxt_gnt = 7'h00;
		if (gap_ff && dn_idle)
			nxt_gnt = 7'h00;
		if (stale_hit(idle_cnt_ff, dn_idle) && gnt_ff[5:0] != 6'h00)
			nxt_gnt = 7'h00;
	end

	// ----------------------------------------
	// arbiter state
	// ----------------------------------------
	// pointers step on synced frame starts, so they trail the pin by a few clocks
	always @(posedge clk_i) begin
		if (reset_i) begin
			ext_ptr_ff <= `RST_PTR;
			all_ptr_ff <= `RST_PTR;
			bridge_turn_ff <= 1'b1;
			gnt_ff <= 7'h00;
			lock_ff <= 6'h00;
			idle_cnt_ff <= 5'h00;
			dn_frame_d_ff <= 1'b0;
			gap_ff <= 1'b0;
		end else if (cfn_ff) begin
			// external arbiter: internal state held quiet
			gnt_ff <= 7'h00;
			lock_ff <= 6'h00;
			idle_cnt_ff <= 5'h00;
			gap_ff <= 1'b0;
			dn_frame_d_ff <= dn_frame_ff;
		end else begin
			dn_frame_d_ff <= dn_frame_ff;
			// new arbitration cycle on each frame start
			if (dn_frame_ff && !dn_frame_d_ff) begin
				bridge_turn_ff <= ~bridge_turn_ff;
				// in mode low, externals move only on the frames the bridge did not lead
				if (!bridge_turn_ff || arb_mode_i)
					ext_ptr_ff <= ptr_next(ext_ptr_ff, 3'h5);
				all_ptr_ff <= ptr_next(all_ptr_ff, 3'h6);
			end
			gnt_ff <= nxt_gnt;
			gap_ff <= (gnt_ff != 7'h00) && (nxt_gnt == 7'h00);
			// idle-grant watchdog for external masters
			if (gnt_ff[5:0] != 6'h00 && nxt_gnt == gnt_ff && dn_idle)
				idle_cnt_ff <= idle_cnt_ff + 5'h01;
			else
				idle_cnt_ff <= 5'h00;
			// lockout ends once the request is seen released for a clock
			if (stale_hit(idle_cnt_ff, dn_idle))
				lock_ff <= (lock_ff | gnt_ff[5:0]) & req_ff;
			else
				lock_ff <= lock_ff & req_ff;
		end
	end

	// ----------------------------------------
	// downstream pins and bridge master end
	// ----------------------------------------
	wire ext_gnt = req_ff[0]; // request pin 0 as grant input
	wire [2:0] dn_step = master_step(dn_need_i, 1'b0, ext_gnt, dn_idle, dn_req_ext_ff);
	// bridge owns the idle bus and still has work for it
	wire bridge_go = nxt_gnt[6] && gnt_ff[6] && dn_idle && dn_need_i;
	// both buses held, or a posted write that needs only one
	wire cross_ok = posted_i || up_owned_ff;

	// pin drivers: internal grants or the repurposed grant pin 0
	always @(posedge clk_i) begin
		if (reset_i) begin
			dn_gnt_n_o <= `RST_GNT_N;
			dn_park_o <= 1'b0;
			dn_req_ext_ff <= 1'b0;
			dn_start_ff <= 1'b0;
			dn_start_o <= 1'b0;
			data_ok_o <= 1'b0;
		end else if (cfn_ff) begin
			dn_req_ext_ff <= dn_step[2];
			dn_gnt_n_o <= {5'h1F, ~dn_step[2]};
			dn_start_ff <= dn_step[1];
			dn_start_o <= dn_step[1];
			dn_park_o <= dn_step[0] && !dn_req_ext_ff;
			data_ok_o <= cross_ok && (dn_step[1] || data_ok_o && dn_need_i);
		end else begin
			dn_req_ext_ff <= 1'b0;
			dn_gnt_n_o <= ~nxt_gnt[5:0];
			// one pulse per ownership, not one per idle clock of a long grant
			dn_start_ff <= bridge_go;
			dn_start_o <= bridge_go && !dn_start_ff;
			// parked by default when no external grant stands and the bus is idle
			dn_park_o <= dn_idle && nxt_gnt[5:0] == 6'h00 && gnt_ff[5:0] == 6'h00;
			data_ok_o <= cross_ok
				&& (gnt_ff[6] && dn_idle && dn_need_i || data_ok_o && dn_need_i);
		end
	end
endmodule // pci_bridge_bus_arbitration

// ==== rtl/prio_pick.v ====
`timescale 1ns/1ps
// ----------------------------------------
// rotating priority picker
// ----------------------------------------
`include "pbarb_defs.vh"
module prio_pick (
	input wire [6:0] req_i,
	input wire [2:0] top_i,
	output reg found_o,
	output reg [2:0] idx_o
);
	integer k;
	reg [2:0] cand;

	// scan downward from top+6 to the top index so the last hit, nearest top, wins
	always @* begin
		found_o = 1'b0;
		idx_o = 3'h0;
		cand = 3'h0;
		for (k = 6; k >= 0; k = k - 1) begin
			if ({29'h0, top_i} + k >= 7) begin
				cand = top_i + k[2:0] - 3'h7;
			end else begin
				cand = top_i + k[2:0];
			end
			if (req_i[cand]) begin
				found_o = 1'b1;
				idx_o = cand;
			end
		end
	end
endmodule // prio_pick
